// ===== design/swid_pkg.sv
// Constants shared by the single-wire identification slave.
// Assumes a 20 MHz system clock; times are in microseconds.
package swid_pkg;
    localparam int CLK_MHZ            = 20;
    localparam int RESET_DETECT_US    = 480;
    localparam int PRESENCE_WAIT_US   = 30;
    localparam int PRESENCE_LOW_US    = 120;
    localparam int SAMPLE_POINT_US    = 30;
    localparam int READ_HOLD_US       = 30;
    localparam int RESET_DETECT_CYC   = RESET_DETECT_US * CLK_MHZ;
    localparam int PRESENCE_WAIT_CYC  = PRESENCE_WAIT_US * CLK_MHZ;
    localparam int PRESENCE_LOW_CYC   = PRESENCE_LOW_US * CLK_MHZ;
    localparam int SAMPLE_POINT_CYC   = SAMPLE_POINT_US * CLK_MHZ;
    localparam int READ_HOLD_CYC      = READ_HOLD_US * CLK_MHZ;
    localparam int CODE_BITS          = 64;
    localparam int DATA_BITS          = 56;
    localparam logic [7:0] CRC_POLY   = 8'h8c;
    localparam logic [7:0] CRC_RESET  = 8'h00;
    localparam logic [7:0] CMD_READ_A = 8'h33;
    localparam logic [7:0] CMD_READ_B = 8'h0f;
    localparam logic [7:0] CMD_SEARCH = 8'hf0;
    localparam logic [7:0] FAMILY_DEF = 8'h01;
    localparam logic [47:0] SERIAL_DEF = 48'h0000_0000_0001;

    typedef enum logic [2:0] {
        SWID_IDLE, SWID_PWAIT, SWID_PLOW, SWID_CMD, SWID_SEND,
        SWID_STOP
    } swid_state_e;

    // One CRC step: reflected form of x^8+x^5+x^4+1.
    function automatic logic [7:0] swid_crc_step(input logic [7:0] c,
                                                 input logic       b);
        logic fb;
        fb = c[0] ^ b;
        swid_crc_step = (c >> 1) ^ (fb ? CRC_POLY : CRC_RESET);
    endfunction : swid_crc_step
endpackage : swid_pkg

// ===== design/swid_slave.sv
// Slave end of a single-wire identification link.
// Assumes an open-drain line with an external pull-up and one bus master.
//
// How it works
// R1 - Hold 64-bit code: family, serial, checksum.
// R2 - Checksum uses x^8+x^5+x^4+1 shift-XOR generator.
// R3 - Checksum starts zero, family LSB first, serial.
// R4 - Feeding checksum bits returns generator to zero.
// R5 - Line driven open-drain only, wired-AND.
// R6 - Master leaves line high while pausing.
// R7 - Transaction starts with reset then presence.
// R8 - Commands are exactly eight write slots.
// R9 - Read commands send family, serial, checksum.
// R10 - Search sends bit, complement, reads choice.
// R11 - Search mismatch drops device until reset.
// R12 - Master reads two zeros as both present.
// R13 - Unsupported commands leave line undriven.
// R14 - After reset release, wait then pull presence.
// R15 - Master samples presence at sample time.
// R16 - Each falling edge starts the slot timer.
// R17 - Master releases write-one early.
// R18 - Master holds write-zero low long enough.
// R19 - Device ready after the recovery interval.
// R20 - Read zero pulls low until timer ends.
// R21 - Master samples read slot inside window.
// R22 - Slew-limited master extends reset pulse.
// R23 - Presence waits 15-60 us, lasts 60-240 us.
// R24 - Master reset low at least 480 us; the bench master holds it low 2700 cycles (135 us).
// R25 - Long low aborts everything, answers presence.
// R26 - Written bit sampled mid-window, LSB first.
// R27 - After sequence or ignored command, stay quiet.
`timescale 1ns/1ns
`default_nettype none
module swid_slave
    import swid_pkg::*;
#(
    parameter int          RESET_CYC   = RESET_DETECT_CYC,
    parameter logic [7:0]  FAMILY      = FAMILY_DEF,  // Arbitrary value.
    parameter logic [47:0] SERIAL      = SERIAL_DEF   // Arbitrary value.
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic line_in,
    output logic      line_out,
    output logic      line_oe_n,
    output logic      presence_active,
    output logic      cmd_valid,
    output logic [7:0] cmd_code
);
    if (RESET_CYC <= PRESENCE_LOW_CYC + 8
        || RESET_CYC > 32'h0000_ffff) begin : g_bad_reset_cyc
        $error("RESET_CYC out of range");
    end

    function automatic logic [7:0] crc_of(input logic [55:0] d);
        logic [7:0] c;
        c = CRC_RESET;
        for (int i = 0; i < DATA_BITS; i++) begin
            c = swid_crc_step(c, d[i]);
        end
        crc_of = c;
    endfunction : crc_of

    function automatic logic [7:0] crc_resid(input logic [63:0] d);
        logic [7:0] c;
        c = CRC_RESET;
        for (int i = 0; i < CODE_BITS; i++) begin
            c = swid_crc_step(c, d[i]);
        end
        crc_resid = c;
    endfunction : crc_resid

    localparam logic [55:0] DATA_FIELD = {SERIAL, FAMILY};
    localparam logic [63:0] CODE = {crc_of(DATA_FIELD), DATA_FIELD}; // R1 R2 R3

    logic        sync1_reg, sync2_reg, prev_reg;
    swid_state_e st_reg, st_next;
    logic [15:0] low_reg, low_next;
    logic [15:0] tmr_reg, tmr_next;
    logic [6:0]  bit_reg, bit_next;
    logic [1:0]  phase_reg, phase_next;
    logic        search_reg, search_next;
    logic [7:0]  cmd_reg, cmd_next;
    logic        drive_reg, drive_next;
    logic        slot_reg, slot_next;
    logic        cv_reg, cv_next;
    logic        fall, rise, cur_bit;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            prev_reg  <= 1'b1;
        end else begin
            sync1_reg <= line_in;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    assign fall    = prev_reg & ~sync2_reg;  // R16
    assign rise    = ~prev_reg & sync2_reg;
    assign cur_bit = CODE[bit_reg[5:0]];

    always_comb begin
        st_next     = st_reg;
        low_next    = sync2_reg ? 16'h0000
                      : (low_reg == 16'hffff ? low_reg : low_reg + 16'h0001);
        tmr_next    = (tmr_reg == 16'hffff) ? tmr_reg : tmr_reg + 16'h0001;
        bit_next    = bit_reg;
        phase_next  = phase_reg;
        search_next = search_reg;
        cmd_next    = cmd_reg;
        drive_next  = drive_reg;
        slot_next   = slot_reg;
        cv_next     = 1'b0;
        if (fall) begin
            tmr_next  = 16'h0000;  // R16
            slot_next = 1'b1;
        end
        case (st_reg)
            SWID_IDLE: begin
                drive_next = 1'b0;
            end
            SWID_PWAIT: begin
                if (tmr_reg >= 16'(PRESENCE_WAIT_CYC - 1)) begin
                    st_next    = SWID_PLOW;  // R14 R23
                    tmr_next   = 16'h0000;
                    drive_next = 1'b1;
                end
            end
            SWID_PLOW: begin
                if (tmr_reg >= 16'(PRESENCE_LOW_CYC - 1)) begin
                    st_next    = SWID_CMD;  // R7
                    drive_next = 1'b0;
                    slot_next  = 1'b0;
                    bit_next   = 7'h00;
                end
            end
            SWID_CMD: begin
                if (slot_reg && !fall
                    && tmr_reg == 16'(SAMPLE_POINT_CYC)) begin
                    cmd_next  = {sync2_reg, cmd_reg[7:1]};  // R26
                    slot_next = 1'b0;
                    bit_next  = bit_reg + 7'h01;
                    if (bit_reg == 7'h07) begin  // R8
                        cv_next    = 1'b1;
                        bit_next   = 7'h00;
                        phase_next = 2'h0;
                        if (cmd_next == CMD_READ_A
                            || cmd_next == CMD_READ_B) begin
                            st_next     = SWID_SEND;  // R9
                            search_next = 1'b0;
                        end else if (cmd_next == CMD_SEARCH) begin
                            st_next     = SWID_SEND;  // R10
                            search_next = 1'b1;
                        end else begin
                            st_next = SWID_STOP;  // R13
                        end
                    end
                end
            end
            SWID_SEND: begin
                if (fall) begin
                    // R20: pull low for a zero; phase 1 sends complement.
                    if (phase_reg == 2'h2) begin
                        drive_next = 1'b0;
                    end else if (phase_reg == 2'h1) begin
                        drive_next = cur_bit;
                    end else begin
                        drive_next = ~cur_bit;
                    end
                end else if (slot_reg
                             && tmr_reg == 16'(READ_HOLD_CYC)) begin
                    drive_next = 1'b0;  // R20 R19
                    slot_next  = 1'b0;
                    if (!search_reg) begin
                        bit_next = bit_reg + 7'h01;
                        if (bit_reg == 7'(CODE_BITS - 1)) begin
                            st_next = SWID_STOP;  // R27
                        end
                    end else if (phase_reg != 2'h2) begin
                        phase_next = phase_reg + 2'h1;
                    end else begin
                        phase_next = 2'h0;
                        bit_next   = bit_reg + 7'h01;
                        if (sync2_reg != cur_bit) begin
                            st_next = SWID_STOP;  // R11
                        end else if (bit_reg == 7'(CODE_BITS - 1)) begin
                            st_next = SWID_STOP;  // R27
                        end
                    end
                end
            end
            SWID_STOP: begin
                drive_next = 1'b0;  // R27
            end
            default: begin
                st_next    = SWID_IDLE;
                drive_next = 1'b0;
            end
        endcase
        // R25: a long low aborts anything and arms a presence answer.
        if (!drive_reg && low_reg >= 16'(RESET_CYC)) begin
            st_next    = SWID_IDLE;
            drive_next = 1'b0;
        end
        if (st_reg == SWID_IDLE && low_reg >= 16'(RESET_CYC) && rise) begin
            st_next  = SWID_PWAIT;  // R14 R25
            tmr_next = 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg     <= SWID_IDLE;
            low_reg    <= 16'h0000;
            tmr_reg    <= 16'h0000;
            bit_reg    <= 7'h00;
            phase_reg  <= 2'h0;
            search_reg <= 1'b0;
            cmd_reg    <= 8'h00;
            drive_reg  <= 1'b0;
            slot_reg   <= 1'b0;
            cv_reg     <= 1'b0;
        end else begin
            st_reg     <= st_next;
            low_reg    <= low_next;
            tmr_reg    <= tmr_next;
            bit_reg    <= bit_next;
            phase_reg  <= phase_next;
            search_reg <= search_next;
            cmd_reg    <= cmd_next;
            drive_reg  <= drive_next;
            slot_reg   <= slot_next;
            cv_reg     <= cv_next;
        end
    end

    assign line_out        = 1'b0;        // R5
    assign line_oe_n       = ~drive_reg;  // R5
    assign presence_active = (st_reg == SWID_PLOW);
    assign cmd_valid       = cv_reg;
    assign cmd_code        = cmd_reg;

    AST_CRC_ZERO: assert property (@(posedge clk) // R4
        crc_resid(CODE) == CRC_RESET)
        else $error("stored checksum residue not zero");
    AST_OPEN_DRAIN: assert property (@(posedge clk) // R5
        disable iff (sys_rst) line_out == 1'b0)
        else $error("line driven high");
    AST_PRES_LEN: assert property (@(posedge clk) // R23
        disable iff (sys_rst)
        $rose(presence_active) |-> presence_active [*8])
        else $error("presence too short");
    AST_PWAIT: assert property (@(posedge clk) // R14
        disable iff (sys_rst)
        (st_reg == SWID_PWAIT) |-> line_oe_n)
        else $error("drive during presence wait");
    AST_SILENT: assert property (@(posedge clk) // R13
        disable iff (sys_rst)
        (st_reg == SWID_STOP) |=> line_oe_n)
        else $error("driving while inactive");
    AST_CMD_DONE: assert property (@(posedge clk) // R8
        disable iff (sys_rst)
        cmd_valid |-> $past(st_reg) == SWID_CMD)
        else $error("command outside receive");
    AST_RESET_IDLE: assert property (@(posedge clk) // R25
        disable iff (sys_rst)
        (!drive_reg && low_reg >= 16'(RESET_CYC)) |=> st_reg == SWID_IDLE
                                                   || st_reg == SWID_PWAIT)
        else $error("long low not a reset");
    AST_DROP: assert property (@(posedge clk) // R11
        disable iff (sys_rst)
        (st_reg == SWID_SEND && search_reg && phase_reg == 2'h2 && !fall
         && slot_reg && tmr_reg == 16'(READ_HOLD_CYC)
         && sync2_reg != cur_bit) |=> st_reg == SWID_STOP)
        else $error("mismatch did not drop");
    AST_SAMPLE_LSB: assert property (@(posedge clk) // R26
        disable iff (sys_rst)
        cmd_valid |-> cmd_code[7] == $past(sync2_reg))
        else $error("command bit order");
    COV_PRES: cover property (@(posedge clk) $rose(presence_active));
    COV_READ: cover property (@(posedge clk) cmd_valid
        && cmd_code == CMD_READ_A);
    COV_SEARCH: cover property (@(posedge clk) cmd_valid
        && cmd_code == CMD_SEARCH);
endmodule : swid_slave
`default_nettype wire

// ===== verification/swid_master.sv
// Bus master model driving the shared single-wire line.
// Assumes the bench resolves the wired-AND line from all drivers.
`timescale 1ns/1ns
`default_nettype none
module swid_master (
    input  wire logic clk,
    input  wire logic line,
    output var logic  drive_low
);
    initial drive_low = 1'b0;

    // One slot: low for low_cyc, sample at 280, then recover.
    task automatic slot(input int low_cyc, output logic smp);
        int gap;
        gap = $urandom_range(15, 0);
        for (int i = 0; i < 650 + gap; i++) begin
            @(negedge clk);
            drive_low = (i < low_cyc);
            if (i == 280)
                smp = line;
        end
    endtask : slot

    task automatic write_bit(input logic b);
        logic unused;
        slot(b ? 20 : 630, unused);
    endtask : write_bit

    task automatic bus_reset(output logic pres);
        for (int i = 0; i < 5800; i++) begin
            @(negedge clk);
            drive_low = (i < 2700);
            if (i == 4100)
                pres = line;
        end
    endtask : bus_reset
endmodule : swid_master
`default_nettype wire

// ===== verification/tb_single_wire_id_slave.sv
// Self-checking bench for the single-wire identification slave.
// Assumes swid_master as the far side and a pull-up on the line.
`timescale 1ns/1ns
`default_nettype none
module tb_single_wire_id_slave
    import swid_pkg::*;
;
    localparam logic [7:0]  FAM = 8'h2d;              // Arbitrary value.
    localparam logic [47:0] SER = 48'h3a5c_0f1e_9b27; // Arbitrary value.
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        line_out, line_oe_n, presence_active, cmd_valid;
    logic [7:0]  cmd_code, got_cmd;
    logic        drive_low, pres_seen, b, c;
    wire logic   line;
    int          failures = 0;
    int          compares = 0;
    logic [7:0]  rd_cmd[2] = '{CMD_READ_A, CMD_READ_B};
    logic [7:0]  mute[2] = '{8'h55, 8'hcc};

    always #25 clk = ~clk;
    assign line = ~drive_low
                  && (line_oe_n !== 1'b0 || line_out === 1'b1);

    always @(posedge clk) begin
        if (cmd_valid === 1'b1)
            got_cmd <= cmd_code;
        if (drive_low)
            pres_seen <= 1'b0;
        else if (presence_active === 1'b1)
            pres_seen <= 1'b1;
    end

    swid_slave #(.RESET_CYC(2600), .FAMILY(FAM), .SERIAL(SER)) uut (
        .clk(clk), .sys_rst(sys_rst), .line_in(line),
        .line_out(line_out), .line_oe_n(line_oe_n),
        .presence_active(presence_active),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code));
    swid_master m (.clk(clk), .line(line), .drive_low(drive_low));

    function automatic int crc_next(input int cr, input logic d);
        crc_next = (cr >> 1) ^ (((cr ^ int'(d)) & 1) ? 'h8c : 0);
    endfunction : crc_next

    task automatic check(input logic ok, input string msg);
        compares++;
        if (!ok) begin
            failures++;
            $display("mismatch %0t %s", $time, msg);
        end
    endtask : check

    task automatic do_reset();
        logic p;
        m.bus_reset(p);
        check(p === 1'b0 && pres_seen === 1'b1, "presence");
    endtask : do_reset

    task automatic send_cmd(input logic [7:0] cmd);
        for (int i = 0; i < 8; i++)
            m.write_bit(cmd[i]);
        check(got_cmd === cmd, "command code");
    endtask : send_cmd

    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    initial begin
        #8_000_000;
        failures++;
        summarize();
    end

    initial begin
        int crc;
        int k;
        logic [63:0] code;
        void'($urandom(32'h51e8));
        code = {8'h00, SER, FAM};
        crc = 0;
        for (int i = 0; i < 56; i++)
            crc = crc_next(crc, code[i]);
        code[63:56] = crc[7:0];
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        foreach (rd_cmd[j]) begin
            do_reset();
            send_cmd(rd_cmd[j]);
            crc = 0;
            for (int i = 0; i < ((j == 0) ? 64 : 4); i++) begin
                m.slot(20, b);
                check(b === code[i], "read bit");
                crc = crc_next(crc, b);
            end
            if (j == 0)
                check(crc == 0, "checksum residue");
            $display("read test %0d done", j);
        end
        do_reset();
        send_cmd(CMD_SEARCH);
        k = $urandom_range(4, 1);
        for (int i = 0; i < k + 2; i++) begin
            m.slot(20, b);
            m.slot(20, c);
            if (i <= k)
                check(b === code[i] && c === ~code[i], "pair");
            else
                check(b === 1'b1 && c === 1'b1, "dropped");
            m.write_bit((i < k) ? code[i] : ~code[i]);
        end
        $display("search test done");
        foreach (mute[j]) begin
            do_reset();
            send_cmd(mute[j]);
            m.slot(20, b);
            check(b === 1'b1, "silent");
            $display("unsupported test %0d done", j);
        end
        summarize();
    end
endmodule : tb_single_wire_id_slave
`default_nettype wire
